// ---- verilog/ddc_sync_ctrl.sv ----
// register bank, sync distribution and fast detect pins of the downconverter
`timescale 1ns/1ps
`include "ddc_ctrl_cfg.svh"
module ddc_sync_ctrl
    import ddc_ctrl_pkg::*;
#(
    parameter int MAG_W = 13
) (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               nrst,
    // register access
    input  wire logic [`ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [7:0]         reg_rdata,
    // sync
    input  wire logic               sync_pin,
    output sync_targets_t           sync_out,
    // filter and mix control
    output logic                    fir_enable,
    output logic                    fir_unity_gain,
    output logic                    complex_out,
    output logic                    mix_bypass,
    output logic      [1:0]         mix_start_state,
    output logic                    halfband_alt_phase,
    output logic                    halfband_reversal,
    output logic                    halfband_highpass,
    // oscillator control
    output logic                    osc_enable,
    output logic                    osc_amp_dither,
    output logic                    osc_phase_dither,
    output logic      [31:0]        tuning_word,
    output logic      [15:0]        phase_start,
    output logic                    osc_load,
    // channel data and status
    input  wire logic [MAG_W-1:0]   magnitude_a,
    input  wire logic [MAG_W-1:0]   magnitude_b,
    input  wire logic               chan_a_on,
    input  wire logic               chan_b_on,
    input  wire logic               lvds_interleaved,
    input  wire logic [19:0]        monitor_result_a,
    input  wire logic [19:0]        monitor_result_b,
    // fast detect pins
    output logic      [3:0]         fast_detect_pins_o,
    output logic      [3:0]         fast_detect_pins_oe
);
    logic          rst_meta_q;
    logic          rst_n;
    logic [7:0]    sync_gate_q;
    logic [1:0]    mix_ctrl_q;
    logic [1:0]    mix_start_q;
    logic [3:0]    filter_mode_q;
    logic [2:0]    halfband_q;
    logic [3:0]    detect_q;
    logic [2:0]    coarse_q;
    logic [12:0]   fine_high_q;
    logic [12:0]   fine_low_q;
    logic [2:0]    osc_ctrl_q;
    logic [31:0]   tune_q;
    logic [15:0]   phase_q;
    logic          osc_en_last_q;
    logic          lane_q;
    logic          sync_edge;
    logic          master;
    logic          wr_gate;
    logic          wr_mix;
    logic [7:0]    rd_d;
    detect_flags_t flags_a;
    detect_flags_t flags_b;

    // reset released through two flops; assert stays asynchronous
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    sync_edge_detect u_sync (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .sync_pin  (sync_pin),
        .sync_edge (sync_edge)
    );

    assign master  = sync_gate_q[`BIT_MASTER];
    assign wr_gate = reg_wr && reg_addr == `OFS_SYNC_GATE;
    assign wr_mix  = reg_wr && reg_addr == `OFS_QUARTER_MIX;

    // sync gating register: hardware clears one-shot enables, a host write wins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_gate_q <= `RST_BYTE;
        end else if (wr_gate) begin
            sync_gate_q <= reg_wdata;
        end else if (sync_edge && master) begin
            if (sync_gate_q[`BIT_HB_EN] && sync_gate_q[`BIT_HB_ONCE]) begin
                sync_gate_q[`BIT_HB_EN] <= 1'b0;
            end
            if (sync_gate_q[`BIT_OSC_EN] && sync_gate_q[`BIT_OSC_ONCE]) begin
                sync_gate_q[`BIT_OSC_EN] <= 1'b0;
            end
            if (sync_gate_q[`BIT_DIV_EN] && sync_gate_q[`BIT_DIV_ONCE]) begin
                sync_gate_q[`BIT_DIV_EN] <= 1'b0;
            end
        end
    end

    // mixer control; the one-shot clears the mixer's own enable, not master
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mix_ctrl_q  <= '0;
            mix_start_q <= '0;
        end else if (wr_mix) begin
            mix_ctrl_q  <= reg_wdata[`BIT_MIX_ONCE:`BIT_MIX_EN];
            mix_start_q <= reg_wdata[5:4];
        end else if (sync_edge && master && mix_ctrl_q[`BIT_MIX_EN] && mix_ctrl_q[`BIT_MIX_ONCE]) begin
            mix_ctrl_q[`BIT_MIX_EN] <= 1'b0;
        end
    end

    // plain configuration registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            filter_mode_q <= '0;
            halfband_q    <= `RST_HALFBAND;
            detect_q      <= '0;
            coarse_q      <= '0;
            fine_high_q   <= '0;
            fine_low_q    <= '0;
            osc_ctrl_q    <= '0;
            tune_q        <= '0;
            phase_q       <= '0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `OFS_FILTER_MODE:  filter_mode_q       <= reg_wdata[3:0];
                `OFS_HALFBAND:     halfband_q          <= reg_wdata[3:1];
                `OFS_DETECT_PIN:   detect_q            <= reg_wdata[3:0];
                `OFS_COARSE_HIGH:  coarse_q            <= reg_wdata[2:0];
                `OFS_FINE_HIGH_LO: fine_high_q[7:0]    <= reg_wdata;
                `OFS_FINE_HIGH_HI: fine_high_q[12:8]   <= reg_wdata[4:0];
                `OFS_FINE_LOW_LO:  fine_low_q[7:0]     <= reg_wdata;
                `OFS_FINE_LOW_HI:  fine_low_q[12:8]    <= reg_wdata[4:0];
                `OFS_OSC_CTRL:     osc_ctrl_q          <= reg_wdata[2:0];
                `OFS_TUNE_0:       tune_q[7:0]         <= reg_wdata;
                `OFS_TUNE_1:       tune_q[15:8]        <= reg_wdata;
                `OFS_TUNE_2:       tune_q[23:16]       <= reg_wdata;
                `OFS_TUNE_3:       tune_q[31:24]       <= reg_wdata;
                `OFS_PHASE_LO:     phase_q[7:0]        <= reg_wdata;
                `OFS_PHASE_HI:     phase_q[15:8]       <= reg_wdata;
                default:           ;
            endcase
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rd_d = 8'h00;
        unique case (reg_addr)
            `OFS_SYNC_GATE:    rd_d = sync_gate_q;
            `OFS_QUARTER_MIX:  rd_d = {2'h0, mix_start_q, 2'h0, mix_ctrl_q[1:0]};
            `OFS_FILTER_MODE:  rd_d = {4'h0, filter_mode_q};
            `OFS_HALFBAND:     rd_d = {4'h0, halfband_q, 1'b1};
            `OFS_DETECT_PIN:   rd_d = {4'h0, detect_q};
            `OFS_COARSE_HIGH:  rd_d = {5'h00, coarse_q};
            `OFS_FINE_HIGH_LO: rd_d = fine_high_q[7:0];
            `OFS_FINE_HIGH_HI: rd_d = {3'h0, fine_high_q[12:8]};
            `OFS_FINE_LOW_LO:  rd_d = fine_low_q[7:0];
            `OFS_FINE_LOW_HI:  rd_d = {3'h0, fine_low_q[12:8]};
            `OFS_RESULT_A_TOP: rd_d = {4'h0, monitor_result_a[19:16]};
            `OFS_RESULT_B_LOW: rd_d = monitor_result_b[7:0];
            `OFS_RESULT_B_MID: rd_d = monitor_result_b[15:8];
            `OFS_RESULT_B_TOP: rd_d = {4'h0, monitor_result_b[19:16]};
            `OFS_OSC_CTRL:     rd_d = {5'h00, osc_ctrl_q};
            `OFS_TUNE_0:       rd_d = tune_q[7:0];
            `OFS_TUNE_1:       rd_d = tune_q[15:8];
            `OFS_TUNE_2:       rd_d = tune_q[23:16];
            `OFS_TUNE_3:       rd_d = tune_q[31:24];
            `OFS_PHASE_LO:     rd_d = phase_q[7:0];
            `OFS_PHASE_HI:     rd_d = phase_q[15:8];
            default:           rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_d;
        end
    end

    // sync distribution, one cycle after the detected edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_out <= '0;
        end else begin
            sync_out.monitor    <= sync_edge && master && sync_gate_q[`BIT_MON_EN];
            sync_out.halfband   <= sync_edge && master && sync_gate_q[`BIT_HB_EN];
            sync_out.oscillator <= sync_edge && master && sync_gate_q[`BIT_OSC_EN];
            sync_out.divider    <= sync_edge && master && sync_gate_q[`BIT_DIV_EN];
            sync_out.mix        <= sync_edge && master && mix_ctrl_q[`BIT_MIX_EN];
        end
    end

    // phase offset reload on oscillator start or its sync
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_en_last_q <= 1'b0;
            osc_load      <= 1'b0;
        end else begin
            osc_en_last_q <= osc_ctrl_q[0];
            osc_load      <= (osc_ctrl_q[0] && !osc_en_last_q)
                             || (sync_edge && master && sync_gate_q[`BIT_OSC_EN]);
        end
    end

    // control levels straight from their registers
    assign fir_enable         = filter_mode_q[0];
    assign complex_out        = filter_mode_q[1];
    assign mix_bypass         = filter_mode_q[2];
    assign fir_unity_gain     = filter_mode_q[3];
    assign mix_start_state    = mix_start_q;
    assign halfband_highpass  = halfband_q[0];
    assign halfband_reversal  = halfband_q[1];
    assign halfband_alt_phase = halfband_q[2];
    assign osc_enable         = osc_ctrl_q[0];
    assign osc_amp_dither     = osc_ctrl_q[1];
    assign osc_phase_dither   = osc_ctrl_q[2];
    assign tuning_word        = tune_q;
    assign phase_start        = phase_q;

    // per-channel threshold flags
    threshold_compare #(.MAG_W(MAG_W)) u_cmp_a (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .magnitude   (magnitude_a),
        .fine_high   (fine_high_q),
        .fine_low    (fine_low_q),
        .coarse_code (coarse_q),
        .flags       (flags_a)
    );

    threshold_compare #(.MAG_W(MAG_W)) u_cmp_b (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .magnitude   (magnitude_b),
        .fine_high   (fine_high_q),
        .fine_low    (fine_low_q),
        .coarse_code (coarse_q),
        .flags       (flags_b)
    );

    // two pins per channel when not interleaved, the pair repeated on all four when interleaved; the mode picks which pair of flags they carry
    function automatic logic [1:0] pick_flags(input logic [2:0] mode, input detect_flags_t f);
        unique case (mode)
            3'h0:    pick_flags = {f.coarse_upper, f.fine_upper_flag};
            3'h1:    pick_flags = {f.fine_upper_flag, f.fine_lower_flag};
            3'h2:    pick_flags = {f.coarse_upper, f.fine_lower_flag};
            default: pick_flags = {f.coarse_upper, f.fine_upper_flag};
        endcase
    endfunction : pick_flags

    // interleaved lanes alternate channels each cycle unless one is off
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lane_q              <= 1'b0;
            fast_detect_pins_o  <= '0;
            fast_detect_pins_oe <= '0;
        end else begin
            lane_q <= ~lane_q;
            if (lvds_interleaved) begin
                if (chan_a_on && (!chan_b_on || !lane_q)) begin
                    fast_detect_pins_o <= {2{pick_flags(detect_q[3:1], flags_a)}};
                end else begin
                    fast_detect_pins_o <= {2{pick_flags(detect_q[3:1], flags_b)}};
                end
                fast_detect_pins_oe <= {4{detect_q[0] && (chan_a_on || chan_b_on)}};
            end else begin
                fast_detect_pins_o  <= {pick_flags(detect_q[3:1], flags_b),
                                        pick_flags(detect_q[3:1], flags_a)};
                fast_detect_pins_oe <= {4{detect_q[0]}};
            end
        end
    end

    sequence seq_fire(logic en);
        sync_edge && master && en;
    endsequence

    chk_master_gate_all: assert property (@(posedge core_clk) disable iff (!rst_n)
        sync_out != '0 |-> $past(master)) else $error("sync passed without master enable");
    chk_monitor_forward: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_fire(sync_gate_q[`BIT_MON_EN]) |=> sync_out.monitor) else $error("monitor sync lost");
    chk_halfband_forward: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_fire(sync_gate_q[`BIT_HB_EN]) |=> sync_out.halfband) else $error("halfband sync lost");
    chk_halfband_once: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_fire(sync_gate_q[`BIT_HB_EN] && sync_gate_q[`BIT_HB_ONCE] && !wr_gate)
        |=> !sync_gate_q[`BIT_HB_EN] ##1 !sync_out.halfband) else $error("halfband one-shot kept enable");
    chk_osc_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
        sync_out.oscillator |-> osc_load) else $error("oscillator sync without phase reload");
    chk_osc_once: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_fire(sync_gate_q[`BIT_OSC_EN] && sync_gate_q[`BIT_OSC_ONCE] && !wr_gate)
        |=> !sync_gate_q[`BIT_OSC_EN]) else $error("oscillator one-shot kept enable");
    chk_divider_once: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_fire(sync_gate_q[`BIT_DIV_EN] && sync_gate_q[`BIT_DIV_ONCE] && !wr_gate)
        |=> sync_out.divider && !sync_gate_q[`BIT_DIV_EN]) else $error("divider one-shot wrong");
    chk_mix_once: assert property (@(posedge core_clk) disable iff (!rst_n)
        seq_fire(mix_ctrl_q[`BIT_MIX_EN] && mix_ctrl_q[`BIT_MIX_ONCE] && !wr_mix && !wr_gate)
        |=> sync_out.mix && !mix_ctrl_q[`BIT_MIX_EN] && master) else $error("mix one-shot wrong");
    chk_reserved_one: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_rd && reg_addr == `OFS_HALFBAND |=> reg_rdata[0]) else $error("reserved bit not one");
    chk_detect_float: assert property (@(posedge core_clk) disable iff (!rst_n)
        !detect_q[0] ##1 !detect_q[0] |-> fast_detect_pins_oe == 4'h0) else $error("pins driven while off");
endmodule : ddc_sync_ctrl

// ---- verilog/ddc_ctrl_cfg.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef DDC_CTRL_CFG_SVH
`define DDC_CTRL_CFG_SVH
`define ADDR_W            10
`define OFS_SYNC_GATE     10'h100
`define OFS_QUARTER_MIX   10'h101
`define OFS_FILTER_MODE   10'h102
`define OFS_HALFBAND      10'h103
`define OFS_DETECT_PIN    10'h104
`define OFS_COARSE_HIGH   10'h105
`define OFS_FINE_HIGH_LO  10'h106
`define OFS_FINE_HIGH_HI  10'h107
`define OFS_FINE_LOW_LO   10'h108
`define OFS_FINE_LOW_HI   10'h109
`define OFS_RESULT_A_TOP  10'h118
`define OFS_RESULT_B_LOW  10'h119
`define OFS_RESULT_B_MID  10'h11a
`define OFS_RESULT_B_TOP  10'h11b
`define OFS_OSC_CTRL      10'h11d
`define OFS_TUNE_0        10'h11e
`define OFS_TUNE_1        10'h11f
`define OFS_TUNE_2        10'h120
`define OFS_TUNE_3        10'h121
`define OFS_PHASE_LO      10'h122
`define OFS_PHASE_HI      10'h123
`define RST_BYTE          8'h00
`define RST_HALFBAND      3'h0
`define BIT_MASTER        0
`define BIT_DIV_EN        1
`define BIT_DIV_ONCE      2
`define BIT_OSC_EN        3
`define BIT_OSC_ONCE      4
`define BIT_HB_EN         5
`define BIT_HB_ONCE       6
`define BIT_MON_EN        7
`define BIT_MIX_EN        0
`define BIT_MIX_ONCE      1
`define SYNC_STAGES       2
`endif

// ---- verilog/ddc_ctrl_pkg.sv ----
// types shared by the downconverter control block
package ddc_ctrl_pkg;
    typedef struct packed {
        logic monitor;
        logic halfband;
        logic oscillator;
        logic divider;
        logic mix;
    } sync_targets_t;
    typedef struct packed {
        logic coarse_upper;
        logic fine_upper_flag;
        logic fine_lower_flag;
    } detect_flags_t;
endpackage : ddc_ctrl_pkg

// ---- verilog/sync_edge_detect.sv ----
// external sync input synchroniser and rising edge detector
`timescale 1ns/1ps
module sync_edge_detect (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // pin and event
    input  wire logic sync_pin,
    output logic      sync_edge
);
    logic meta_q;
    logic stable_q;
    logic last_q;

    // meta_q feeds stable_q only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q   <= 1'b0;
            stable_q <= 1'b0;
            last_q   <= 1'b0;
        end else begin
            meta_q   <= sync_pin;
            stable_q <= meta_q;
            last_q   <= stable_q;
        end
    end

    assign sync_edge = stable_q & ~last_q;
endmodule : sync_edge_detect

// ---- verilog/threshold_compare.sv ----
// coarse and fine threshold comparison of one channel magnitude
`timescale 1ns/1ps
module threshold_compare
    import ddc_ctrl_pkg::*;
#(
    parameter int MAG_W = 13
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // magnitude and limits
    input  wire logic [MAG_W-1:0] magnitude,
    input  wire logic [MAG_W-1:0] fine_high,
    input  wire logic [MAG_W-1:0] fine_low,
    input  wire logic [2:0]       coarse_code,
    // flags
    output detect_flags_t         flags
);
    logic [MAG_W-1:0] coarse_level;

    // each code step halves the coarse level from full scale
    assign coarse_level = {MAG_W{1'b1}} >> coarse_code;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= '0;
        end else begin
            flags.coarse_upper    <= magnitude >= coarse_level;
            flags.fine_upper_flag <= magnitude > fine_high;
            flags.fine_lower_flag <= magnitude < fine_low;
        end
    end
endmodule : threshold_compare

// ---- verification/sync_source.sv ----
// external sync source driving the sync pin
`timescale 1ns/1ps
module sync_source (
    // clock
    input  wire logic core_clk,
    // request
    input  wire logic fire,
    // pin
    output logic      sync_pin
);
    logic [1:0] hold_q;
    initial sync_pin = 1'b0;
    initial hold_q = 2'h0;
    // held high four cycles so the two input flops cannot miss it
    always @(posedge core_clk) begin
        if (fire) begin
            hold_q   <= 2'h3;
            sync_pin <= 1'b1;
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end else begin
            sync_pin <= 1'b0;
        end
    end
endmodule : sync_source

// ---- verification/test_ddc_sync_ctrl.sv ----
// self-checking bench for the downconverter control block
`timescale 1ns/1ps
`include "ddc_ctrl_cfg.svh"
module test_ddc_sync_ctrl
    import ddc_ctrl_pkg::*;
;
    logic          core_clk  = 1'b0;
    logic          nrst      = 1'b0;
    logic          reg_wr    = 1'b0;
    logic          reg_rd    = 1'b0;
    logic          fire      = 1'b0;
    logic          clr       = 1'b0;
    logic          cha_on    = 1'b1;
    logic          chb_on    = 1'b1;
    logic          ilv       = 1'b0;
    logic [9:0]    reg_addr  = 10'h000;
    logic [7:0]    reg_wdata = 8'h00;
    logic [12:0]   mag_a     = 13'h0000;
    logic [12:0]   mag_b     = 13'h0000;
    logic [7:0]    reg_rdata;
    logic          sync_pin;
    sync_targets_t sync_out;
    sync_targets_t seen;
    logic          load_seen;
    logic          fir_enable, fir_unity_gain, complex_out, mix_bypass, osc_load;
    logic          hb_alt, hb_rev, hb_hp;
    logic [1:0]    mix_start_state;
    logic [15:0]   phase_start;
    logic          osc_en, osc_amp, osc_phase;
    logic [31:0]   tune;
    logic [3:0]    pins_o, pins_oe;
    int            fails      = 0;
    int            n_compared = 0;

    always #20 core_clk = ~core_clk;

    sync_source src (.core_clk(core_clk), .fire(fire), .sync_pin(sync_pin));

    ddc_sync_ctrl #(.MAG_W(13)) uut (
        .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_pin(sync_pin),
        .sync_out(sync_out), .fir_enable(fir_enable), .fir_unity_gain(fir_unity_gain),
        .complex_out(complex_out), .mix_bypass(mix_bypass), .mix_start_state(mix_start_state),
        .halfband_alt_phase(hb_alt), .halfband_reversal(hb_rev), .halfband_highpass(hb_hp),
        .osc_enable(osc_en), .osc_amp_dither(osc_amp), .osc_phase_dither(osc_phase), .tuning_word(tune),
        .phase_start(phase_start), .osc_load(osc_load), .magnitude_a(mag_a), .magnitude_b(mag_b),
        .chan_a_on(cha_on), .chan_b_on(chb_on), .lvds_interleaved(ilv),
        .monitor_result_a(20'h00000), .monitor_result_b(20'h5a3c1),
        .fast_detect_pins_o(pins_o), .fast_detect_pins_oe(pins_oe)
    );

    // sticky capture, since target pulses last a single cycle
    always @(posedge core_clk) begin
        if (clr) begin
            seen      <= '0;
            load_seen <= 1'b0;
        end else begin
            seen      <= seen | sync_out;
            load_seen <= load_seen | osc_load;
        end
    end

    task close_out;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask : rd

    task pulse(input logic [4:0] e_tgt, input logic e_load);
        @(posedge core_clk);
        clr  <= 1'b1;
        fire <= 1'b1;
        @(posedge core_clk);
        clr  <= 1'b0;
        fire <= 1'b0;
        repeat (10) @(posedge core_clk);
        #1;
        chk(seen, e_tgt);
        chk(load_seen, e_load);
    endtask : pulse

    task fd(input logic [12:0] a, input logic [12:0] b, input logic [3:0] e_o, input logic [3:0] e_oe);
        @(posedge core_clk);
        mag_a <= a;
        mag_b <= b;
        repeat (4) @(posedge core_clk);
        #1;
        chk(pins_o & e_oe, e_o);
        chk(pins_oe, e_oe);
    endtask : fd

    initial begin
        #(40 * 5000);
        fails++;
        close_out();
    end

    initial begin
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(`OFS_SYNC_GATE, 8'h00);
        rd(`OFS_HALFBAND, 8'h01);
        rd(`OFS_RESULT_B_TOP, 8'h05);
        rd(`OFS_RESULT_B_LOW, 8'hc1);
        rd(10'h110, 8'h00);
        $display("test reset done");
        wr(`OFS_FILTER_MODE, 8'h0f);
        wr(`OFS_HALFBAND, 8'h0e);
        rd(`OFS_HALFBAND, 8'h0f);
        chk({fir_unity_gain, mix_bypass, complex_out, fir_enable}, 4'hf);
        chk({hb_alt, hb_rev, hb_hp}, 3'h7);
        wr(`OFS_FILTER_MODE, 8'h00);
        wr(`OFS_PHASE_LO, 8'h34);
        wr(`OFS_PHASE_HI, 8'h12);
        chk({fir_unity_gain, mix_bypass, complex_out, fir_enable}, 4'h0);
        chk(phase_start, 16'h1234);
        $display("test modes done");
        wr(`OFS_SYNC_GATE, 8'hfe);
        wr(`OFS_QUARTER_MIX, 8'h21);
        chk(mix_start_state, 2'h2);
        pulse(5'h00, 1'b0);
        wr(`OFS_SYNC_GATE, 8'hab);
        pulse(5'h1f, 1'b1);
        rd(`OFS_SYNC_GATE, 8'hab);
        wr(`OFS_SYNC_GATE, 8'hff);
        wr(`OFS_QUARTER_MIX, 8'h23);
        pulse(5'h1f, 1'b1);
        rd(`OFS_SYNC_GATE, 8'hd5);
        rd(`OFS_QUARTER_MIX, 8'h22);
        pulse(5'h10, 1'b0);
        $display("test sync done");
        wr(`OFS_FINE_HIGH_LO, 8'h00);
        wr(`OFS_FINE_HIGH_HI, 8'h08);
        wr(`OFS_FINE_LOW_LO, 8'h00);
        wr(`OFS_FINE_LOW_HI, 8'h01);
        wr(`OFS_DETECT_PIN, 8'h03);
        fd(13'h1000, 13'h0010, 4'h6, 4'hf);
        fd(13'h0800, 13'h0100, 4'h0, 4'hf);
        wr(`OFS_COARSE_HIGH, 8'h03);
        wr(`OFS_DETECT_PIN, 8'h01);
        fd(13'h1000, 13'h03ff, 4'hb, 4'hf);
        wr(`OFS_DETECT_PIN, 8'h05);
        fd(13'h03fe, 13'h00ff, 4'h4, 4'hf);
        ilv    <= 1'b1;
        chb_on <= 1'b0;
        fd(13'h1000, 13'h00ff, 4'ha, 4'hf);
        cha_on <= 1'b0;
        chb_on <= 1'b1;
        fd(13'h1000, 13'h00ff, 4'h5, 4'hf);
        chb_on <= 1'b0;
        fd(13'h1000, 13'h00ff, 4'h0, 4'h0);
        ilv    <= 1'b0;
        cha_on <= 1'b1;
        chb_on <= 1'b1;
        wr(`OFS_DETECT_PIN, 8'h02);
        fd(13'h1000, 13'h0010, 4'h0, 4'h0);
        $display("test detect done");
        wr(`OFS_TUNE_0, 8'h78);
        wr(`OFS_TUNE_1, 8'h56);
        wr(`OFS_TUNE_2, 8'h34);
        wr(`OFS_TUNE_3, 8'h12);
        chk(tune, 32'h12345678);
        clr <= 1'b1;
        wr(`OFS_OSC_CTRL, 8'h07);
        clr <= 1'b0;
        chk({osc_phase, osc_amp, osc_en}, 3'h7);
        repeat (3) @(posedge core_clk);
        #1;
        chk(load_seen, 1'b1);
        rd(`OFS_OSC_CTRL, 8'h07);
        $display("test oscillator done");
        close_out();
    end
endmodule : test_ddc_sync_ctrl
